// ### rtl/abte_regs.vh
// register map, field layout and opcode codes of the add and bit-test executor
// assumes a 32-bit apb bus with byte addresses on paddr[7:0]
`ifndef ABTE_REGS_VH
`define ABTE_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ABTE_OFF_INSTR      8'h00
`define ABTE_OFF_ACC        8'h04
`define ABTE_OFF_STATUS     8'h08
`define ABTE_OFF_FADDR      8'h0c
`define ABTE_OFF_FDATA      8'h10

// ----------------------------------------
// status fields
// ----------------------------------------
`define ABTE_ST_CARRY       0
`define ABTE_ST_DCARRY      1
`define ABTE_ST_ZERO        2
`define ABTE_ST_SKIP        3

// ----------------------------------------
// reset values
// ----------------------------------------
`define ABTE_RST_ACC        8'h00
`define ABTE_RST_INSTR      14'h0000
`define ABTE_RST_FADDR      7'h00
`define ABTE_RST_LATCH      8'h00

// ----------------------------------------
// file address of the pin port
// ----------------------------------------
`define ABTE_PORT_ADDR      7'h06

// ----------------------------------------
// opcode classes
// ----------------------------------------
`define ABTE_OP_ADDF        6'h07
`define ABTE_OP_ANDF        6'h05
`define ABTE_OP_ANDL        6'h39
`define ABTE_OP_ADDL        5'h1f
`define ABTE_OP_BCLR        4'h4
`define ABTE_OP_BSET        4'h5
`define ABTE_OP_TSTC        4'h6
`define ABTE_OP_TSTS        4'h7

`endif

// ### rtl/abte_core.v
// add, and, bit clear/set and bit-test-and-skip executor with 128-byte file
// assumes an apb master on core_clk; pins sampled synchronously
// Notes on behaviour
// RL1: add_literal_to_acc adds an 8-bit literal to acc and updates carry, digit carry and zero.
// RL2: add_acc_to_file adds a file byte to acc, stores by destination bit, sets all three flags.
// RL3: and_literal_with_acc ands a literal into the accumulator and touches only zero.
// RL4: and_acc_with_file ands the file byte, stores by the destination bit, touches only zero.
// RL5: bit_clear_file clears one bit of a file byte and leaves the flags alone.
// RL6: bit_set_file sets one bit of a file byte and leaves the flags alone.
// RL7: test_skip_if_clear on a zero bit turns the next instruction into a no_operation.
// RL8: test_skip_if_clear on a one bit lets the next instruction run and keeps the flags.
// RL9: test_skip_if_set on a one bit turns the next instruction into a no_operation.
// RL10: test_skip_if_set on a zero bit lets the next instruction run and keeps the flags.
// RL11: read-modify-write on the port address takes its operand from the pins, not the latch.
// RL12: zero means an all-zero result, carry is out of bit 7, digit carry out of bit 3.
// RL13: every instruction and every untaken test completes in one instruction cycle.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`include "abte_regs.vh"
`default_nettype none

module abte_core
(
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // pin port
    input  wire [7:0]  port_pins,
    output reg  [7:0]  port_latch_q,
    // program counter skip request
    output reg         skip_req_q
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [7:0]  file_mem [0:127];
    reg [7:0]  acc_q;
    reg [13:0] instr_q;
    reg [6:0]  faddr_q;
    reg        carry_q;
    reg        dcarry_q;
    reg        zero_q;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire setup    = psel & ~penable;
    wire wr_done  = psel & penable & pready & pwrite;
    wire hit_ins  = (paddr == `ABTE_OFF_INSTR);
    wire hit_acc  = (paddr == `ABTE_OFF_ACC);
    wire hit_st   = (paddr == `ABTE_OFF_STATUS);
    wire hit_fa   = (paddr == `ABTE_OFF_FADDR);
    wire hit_fd   = (paddr == `ABTE_OFF_FDATA);
    wire mapped   = hit_ins | hit_acc | hit_st | hit_fa | hit_fd;
    wire exec     = wr_done & hit_ins;

    // ----------------------------------------
    // instruction fields
    // ----------------------------------------
    wire [13:0] op      = pwdata[13:0];
    wire [6:0]  f_addr  = op[6:0];
    wire        dest_f  = op[7];
    wire [2:0]  bit_sel = op[9:7];
    wire [7:0]  literal = op[7:0];

    wire is_addf = (op[13:8] == `ABTE_OP_ADDF);
    wire is_andf = (op[13:8] == `ABTE_OP_ANDF);
    wire is_andl = (op[13:8] == `ABTE_OP_ANDL);
    wire is_addl = (op[13:9] == `ABTE_OP_ADDL);
    wire is_bclr = (op[13:10] == `ABTE_OP_BCLR);
    wire is_bset = (op[13:10] == `ABTE_OP_BSET);
    wire is_tstc = (op[13:10] == `ABTE_OP_TSTC);
    wire is_tsts = (op[13:10] == `ABTE_OP_TSTS);

    // RL11 pins feed port operands
    wire [7:0] f_val = (f_addr == `ABTE_PORT_ADDR) ? port_pins : file_mem[f_addr];
    wire [7:0] fd_rd = (faddr_q == `ABTE_PORT_ADDR) ? port_pins : file_mem[faddr_q];

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    wire [7:0] opnd = (is_addl | is_andl) ? literal : f_val;
    // RL12 carry out of bits 7 and 3
    wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, opnd};
    wire [4:0] sum5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
    wire [7:0] andv = acc_q & opnd;

    wire [7:0] bmask;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_mask
            assign bmask[gi] = (bit_sel == gi);
        end
    endgenerate

    wire       tbit = |(f_val & bmask);

    reg [7:0] res;
    reg       wr_acc;
    reg       wr_file;
    reg       upd_c;
    reg       upd_z;
    reg       skip_now;
    always @*
    begin
        res      = 8'h00;
        wr_acc   = 1'b0;
        wr_file  = 1'b0;
        upd_c    = 1'b0;
        upd_z    = 1'b0;
        skip_now = 1'b0;
        if (!skip_req_q)
        begin
            // RL1 literal add to acc
            if (is_addl)
            begin
                res    = sum9[7:0];
                wr_acc = 1'b1;
                upd_c  = 1'b1;
                upd_z  = 1'b1;
            end
            // RL2 file add by destination
            else if (is_addf)
            begin
                res     = sum9[7:0];
                wr_acc  = ~dest_f;
                wr_file = dest_f;
                upd_c   = 1'b1;
                upd_z   = 1'b1;
            end
            // RL3 literal and, zero only
            else if (is_andl)
            begin
                res    = andv;
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            // RL4 file and by destination
            else if (is_andf)
            begin
                res     = andv;
                wr_acc  = ~dest_f;
                wr_file = dest_f;
                upd_z   = 1'b1;
            end
            // RL5 clear one bit
            else if (is_bclr)
            begin
                res     = f_val & ~bmask;
                wr_file = 1'b1;
            end
            // RL6 set one bit
            else if (is_bset)
            begin
                res     = f_val | bmask;
                wr_file = 1'b1;
            end
            // RL7 RL8 skip on clear bit
            else if (is_tstc)
            begin
                skip_now = ~tbit;
            end
            // RL9 RL10 skip on set bit
            else if (is_tsts)
            begin
                skip_now = tbit;
            end
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        if (hit_ins)
            rd_mux = {18'h00000, instr_q};
        else if (hit_acc)
            rd_mux = {24'h000000, acc_q};
        else if (hit_st)
            rd_mux = {28'h0000000, skip_req_q, zero_q, dcarry_q, carry_q};
        else if (hit_fa)
            rd_mux = {25'h0000000, faddr_q};
        else if (hit_fd)
            rd_mux = {24'h000000, fd_rd};
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            if (setup)
            begin
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= ~mapped;
            end
        end
    end

    // ----------------------------------------
    // execution and register writes
    // ----------------------------------------
    wire fd_wr = wr_done & hit_fd;
    wire [6:0] mem_a = exec ? f_addr : faddr_q;
    wire [7:0] mem_d = exec ? res : pwdata[7:0];
    wire       mem_w = (exec & wr_file) | fd_wr;

    // ----------------------------------------
    // file memory
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        if (mem_w && mem_a != `ABTE_PORT_ADDR)
            file_mem[mem_a] <= mem_d;
    end

    // ----------------------------------------
    // port output latch
    // ----------------------------------------
    // RL11 port writes hit latch
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            port_latch_q <= `ABTE_RST_LATCH;
        else if (mem_w && mem_a == `ABTE_PORT_ADDR)
            port_latch_q <= mem_d;
    end

    // ----------------------------------------
    // skip request
    // ----------------------------------------
    // RL13 one cycle unless skip taken
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            skip_req_q <= 1'b0;
        else if (exec)
            skip_req_q <= skip_now;
    end

    // ----------------------------------------
    // accumulator, flags and file address
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q        <= `ABTE_RST_ACC;
            instr_q      <= `ABTE_RST_INSTR;
            faddr_q      <= `ABTE_RST_FADDR;
            carry_q      <= 1'b0;
            dcarry_q     <= 1'b0;
            zero_q       <= 1'b0;
        end
        else
        begin
            if (exec)
            begin
                instr_q <= op;
                if (wr_acc)
                    acc_q <= res;
                if (upd_c)
                begin
                    carry_q  <= sum9[8];
                    dcarry_q <= sum5[4];
                end
                // RL12 zero on all-zero result
                if (upd_z)
                    zero_q <= (res == 8'h00);
            end
            else if (wr_done)
            begin
                if (hit_acc)
                    acc_q <= pwdata[7:0];
                if (hit_fa)
                    faddr_q <= pwdata[6:0];
                if (hit_st)
                begin
                    carry_q  <= pwdata[`ABTE_ST_CARRY];
                    dcarry_q <= pwdata[`ABTE_ST_DCARRY];
                    zero_q   <= pwdata[`ABTE_ST_ZERO];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### tb/abte_monitor.sv
// assertions on the executor apb answers, skip flag and port latch
// assumes it is bound to abte_core and runs on core_clk
`default_nettype none
module abte_mon
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // port and skip
    input wire logic [7:0]  port_pins,
    input wire logic [7:0]  port_latch_q,
    input wire logic        skip_req_q
);
timeunit 1ns;
timeprecision 1ns;
wire acc_w = psel && penable && pready;
wire bad   = paddr > 8'h10 || paddr[1:0] != 2'h0;
wire iw    = acc_w && pwrite && paddr == 8'h00;
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
// ----------------------------------------
// properties
// ----------------------------------------
property p_rdy; psel && !penable |=> pready; endproperty
a_rdy: assert property (p_rdy) else $error("ready missing after setup");
property p_one; pready |-> psel && penable && $past(psel && !penable); endproperty
a_one: assert property (p_one) else $error("ready outside access");
property p_err; acc_w && bad |-> pslverr && (pwrite || prdata == 32'h0); endproperty
a_err: assert property (p_err) else $error("unmapped access accepted");
property p_ok; acc_w && !bad |-> !pslverr; endproperty
a_ok: assert property (p_ok) else $error("mapped access refused");
property p_skon; $rose(skip_req_q) |-> $past(iw); endproperty
a_skon: assert property (p_skon) else $error("skip rose without instruction");
property p_skof; $fell(skip_req_q) |-> $past(iw); endproperty
a_skof: assert property (p_skof) else $error("skip fell without instruction");
property p_clr; iw && pwdata[13:9] == 5'h1f |=> !skip_req_q; endproperty
a_clr: assert property (p_clr) else $error("skip kept after add");
property p_lat; !$stable(port_latch_q) |-> $past(acc_w && pwrite); endproperty
a_lat: assert property (p_lat) else $error("latch moved without write");
endmodule
bind abte_core abte_mon u_mon
(
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pins(port_pins), .port_latch_q(port_latch_q), .skip_req_q(skip_req_q)
);
`default_nettype wire

// ### tb/add_and_bit_test_exec_test.sv
// random instruction run checked against an integer model of the executor
// assumes abte_core with its apb slave and file window
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module add_and_bit_test_exec_test;
timeunit 1ns;
timeprecision 1ns;
logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0]  paddr = 8'h00, port_pins = 8'h00, acc = 8'h00, lat = 8'h00, pin, mem [128];
logic [31:0] pwdata = 32'h0, rs = 32'hfc88, x, d;
logic [13:0] tbl [8] = '{14'h0700, 14'h0500, 14'h1000, 14'h1400,
                         14'h3e00, 14'h3900, 14'h1800, 14'h1c00};
logic [13:0] op;
logic [6:0]  f;
logic        c = 1'b0, digit_carry_flag = 1'b0, z = 1'b0, skp = 1'b0, er;
wire  [31:0] prdata;
wire  [7:0]  port_latch_q;
wire         pready, pslverr, skip_req_q;
int          num_errors = 0, n_checks = 0, cyc = 0;
abte_core dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pins(port_pins), .port_latch_q(port_latch_q),
    .skip_req_q(skip_req_q));
// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
endfunction
task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                   output logic [31:0] rd, output logic e);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
        @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
endtask
task automatic wrt(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, d, er);
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, d, er);
    `CHK(d, e)
endtask
task automatic ex(input logic [13:0] o);
    logic [7:0] a, r;
    logic [8:0] s;
    a = o[6:0] == 7'h06 ? pin : mem[o[6:0]];
    if (skp)
        skp = 1'b0;
    else
    begin
        casez (o)
            14'b00_0111_????_????, 14'b11_111?_????_????:
            begin
                if (o[13])
                    a = o[7:0];
                s = acc + a;
                digit_carry_flag = acc[3:0] + a[3:0] > 5'h0f;
                {c, r} = s;
                z = r == 8'h00;
            end
            14'b00_0101_????_????, 14'b11_1001_????_????:
            begin
                if (o[13])
                    a = o[7:0];
                r = acc & a;
                z = r == 8'h00;
            end
            14'b01_00??_????_????: r = a & ~(8'h01 << o[9:7]);
            14'b01_01??_????_????: r = a | (8'h01 << o[9:7]);
            14'b01_10??_????_????: skp = !a[o[9:7]];
            14'b01_11??_????_????: skp = a[o[9:7]];
        endcase
        if (o[13] || o[13:12] == 2'b00 && !o[7])
            acc = r;
        else if (o[13:11] == 3'b010 || o[13:12] == 2'b00)
            if (o[6:0] == 7'h06)
                lat = r;
            else
                mem[o[6:0]] = r;
    end
    wrt(8'h00, {18'h0, o});
endtask
// ----------------------------------------
// sequence
// ----------------------------------------
initial
begin
    forever #50 core_clk = ~core_clk;
end
always @(posedge core_clk)
begin
    cyc++;
    if (cyc == 20000)
    begin
        num_errors++;
        summarize();
    end
end
initial
begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(8'h04 * i, 32'h0);
    apb(1'b0, 8'h14, 32'h0, d, er);
    `CHK({er, d}, 33'h1_0000_0000)
    wrt(8'h40, 32'hff);
    wrt(8'h08, 32'hf);
    {z, digit_carry_flag, c} = 3'h7;
    rdc(8'h08, 32'h7);
    for (int i = 0; i < 8; i++)
    begin
        x = rnd();
        mem[32 + i] = x[7:0];
        wrt(8'h0c, 32 + i);
        wrt(8'h10, x[7:0]);
    end
    $display("reset and refusal test done");
    for (int n = 0; n < 400; n++)
    begin
        x = rnd();
        pin = x[7:0];
        port_pins <= pin;
        wrt(8'h04, x[23:16]);
        acc = x[23:16];
        f = x[9] ? 7'h06 : {4'h4, x[12:10]};
        op = tbl[x[31:29]] | (x[30] ? {x[28:26], f} : x[31] ? {x[27], x[7:0]} : {x[26], f});
        ex(op);
        @(negedge core_clk);
        `CHK(skip_req_q, skp)
        `CHK(port_latch_q, lat)
        rdc(8'h00, op);
        rdc(8'h04, acc);
        rdc(8'h08, {skp, z, digit_carry_flag, c});
        wrt(8'h0c, f);
        rdc(8'h10, f == 7'h06 ? pin : mem[f]);
    end
    $display("random instruction test done");
    summarize();
end
endmodule
`default_nettype wire
